// ### logic/serial_flash_protect_hold_params.svh
`ifndef SERIAL_FLASH_PROTECT_HOLD_PARAMS_SVH
`define SERIAL_FLASH_PROTECT_HOLD_PARAMS_SVH

// command opcodes
`define OP_WRITE_ENABLE        8'h06
`define OP_STATUS_WRITE        8'h01
`define OP_STATUS_READ         8'h05
`define OP_CONFIG_READ         8'h35
`define OP_LOCKDOWN_PROTECT    8'h8D
`define OP_QUAD_IO_ENTER       8'h38
`define OP_SECURE_ID_PROGRAM   8'hA5
`define OP_SECURE_ID_LOCKOUT   8'h85
`define OP_PAGE_PROGRAM        8'h02
`define OP_QUAD_PAGE_PROGRAM   8'h32
`define OP_SECTOR_ERASE        8'h20
`define OP_BLOCK32_ERASE       8'h52
`define OP_BLOCK64_ERASE       8'hD8

// bit counts of each command frame
`define BITS_OPCODE            6'h08
`define BITS_ADDR_END          6'h20
`define BITS_STATUS_WRITE      6'h18
`define BITS_ADDR_DATA         6'h28

// status register fields
`define ST_BUSY                0
`define ST_WEL                 1
`define ST_LEVEL0              2
`define ST_LEVEL1              3
`define ST_LOCKDOWN            7

// configuration register fields
`define CF_PIN_FUNCTION_SELECT 1
`define CF_VOLATILE_LOCK       3
`define CF_PROTECT_PIN_ENABLE  7

// reset values
`define STATUS_RESET_LEVEL     1'b1

// array organisation
`define SECTOR_ADDR_MASK       24'hFFF000
`define BLOCK32_ADDR_MASK      24'hFF8000
`define BLOCK64_ADDR_MASK      24'hFF0000
`define SECURE_ID_FACTORY_END  24'h000010
`define SECURE_ID_AREA_END     24'h000800

`endif

// ### logic/serial_flash_protect_hold_pkg.sv
package serial_flash_protect_hold_pkg;
  `include "serial_flash_protect_hold_params.svh"

  typedef enum logic [2:0] {
    ARR_PROGRAM       = 3'h1,
    ARR_ERASE         = 3'h2,
    ARR_SECURE_ID_PGM = 3'h4
  } array_kind_t;

  typedef struct packed {
    array_kind_t kind;
    logic [23:0] addr;
    logic [7:0]  data;
  } array_op_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [15:0] data;
  } cmd_t;

  typedef enum logic [1:0] {
    SYS_IDLE = 2'b01,
    SYS_BUSY = 2'b10
  } sys_state_t;

  function automatic logic [5:0] need_bits(input logic [7:0] op);
    case (op)
      `OP_STATUS_WRITE:                              need_bits = `BITS_STATUS_WRITE;
      `OP_SECURE_ID_PROGRAM, `OP_PAGE_PROGRAM,
      `OP_QUAD_PAGE_PROGRAM:                         need_bits = `BITS_ADDR_DATA;
      `OP_SECTOR_ERASE, `OP_BLOCK32_ERASE,
      `OP_BLOCK64_ERASE:                             need_bits = `BITS_ADDR_END;
      default:                                       need_bits = `BITS_OPCODE;
    endcase
  endfunction : need_bits
endpackage : serial_flash_protect_hold_pkg

// ### logic/sync_two_flop.sv
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= '0;
      o_q    <= '0;
    end else begin
      stage1 <= i_d;
      o_q    <= stage1;
    end
  end
endmodule : sync_two_flop

// ### logic/serial_flash_protect_hold.sv
`include "serial_flash_protect_hold_params.svh"
module serial_flash_protect_hold (
  input  wire logic                                   i_clk_sys,
  input  wire logic                                   i_resetn,
  input  wire logic                                   i_sck,
  input  wire logic                                   i_chip_select_n,
  input  wire logic                                   i_hold_n,
  input  wire logic                                   i_write_protect_n,
  input  wire logic [3:0]                             i_shared_data_lines,
  output logic      [3:0]                             o_shared_data_lines,
  output logic      [3:0]                             o_shared_data_lines_oe,
  input  wire logic                                   i_protect_pin_enable_nv,
  input  wire logic                                   i_secure_id_locked_nv,
  output logic                                        o_protect_pin_enable_nv,
  output logic                                        o_secure_id_locked_nv,
  output logic                                        o_array_valid,
  output serial_flash_protect_hold_pkg::array_op_t    o_array_op,
  input  wire logic                                   i_array_done,
  output logic      [7:0]                             o_status,
  output logic      [7:0]                             o_config,
  output logic                                        o_quad_mode
);
  import serial_flash_protect_hold_pkg::*;

  // ---------------- link domain, rising edge ----------------
  typedef struct packed {
    logic [5:0]  bitcnt;
    logic [39:0] sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic        done;
  } frame_t;

  typedef struct packed {
    logic quad;
    logic tgl;
    cmd_t cmd;
  } keep_t;

  typedef struct packed {
    logic [7:0] osh;
    logic       loaded;
  } out_t;

  frame_t frame, next_frame;
  keep_t  keep, next_keep;
  out_t   outs, next_outs;
  logic   held, next_held;
  logic   link_rst_n;
  logic   freeze;
  logic   wide;
  logic   rd_active;
  logic [15:0] word_link;

  // a high select clears the frame logic; hold itself survives it
  assign link_rst_n = i_resetn & ~i_chip_select_n;
  assign freeze     = ~keep.quad & ~i_hold_n;
  assign wide       = keep.quad | (frame.op == `OP_QUAD_PAGE_PROGRAM && frame.bitcnt >= `BITS_ADDR_END);

  always_comb begin
    next_frame = frame;
    next_keep  = keep;
    if (!freeze && !frame.done) begin
      if (wide) begin
        next_frame.sh     = {frame.sh[35:0], i_shared_data_lines};
        next_frame.bitcnt = frame.bitcnt + 6'h04;
      end else begin
        next_frame.sh     = {frame.sh[38:0], i_shared_data_lines[0]};
        next_frame.bitcnt = frame.bitcnt + 6'h01;
      end
      if (next_frame.bitcnt == `BITS_OPCODE) begin
        next_frame.op = next_frame.sh[7:0];
      end
      if (next_frame.bitcnt == `BITS_ADDR_END) begin
        next_frame.addr = next_frame.sh[23:0];
      end
      if (next_frame.bitcnt >= `BITS_OPCODE && next_frame.bitcnt == need_bits(next_frame.op)) begin
        next_frame.done    = 1'b1;
        next_keep.cmd.op   = next_frame.op;
        next_keep.cmd.addr = (next_frame.bitcnt >= `BITS_ADDR_END) ? next_frame.addr : 24'h000000;
        next_keep.cmd.data = next_frame.sh[15:0];
        next_keep.tgl      = ~keep.tgl;
        if (next_frame.op == `OP_QUAD_IO_ENTER) begin
          next_keep.quad = 1'b1;
        end
      end
    end
  end

  // clock polarity between frames does not matter: only edges inside a frame count
  always_ff @(posedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // mode flag and command snapshot outlive the frame
  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      keep <= '0;
    end else begin
      keep <= next_keep;
    end
  end

  // ---------------- link domain, falling edge; read-word sync on rising edge ----------------
  assign rd_active = frame.done && (frame.op == `OP_STATUS_READ || frame.op == `OP_CONFIG_READ);

  always_comb begin
    next_outs = outs;
    if (rd_active && !held) begin
      if (!outs.loaded) begin
        next_outs.osh    = (frame.op == `OP_STATUS_READ) ? word_link[15:8] : word_link[7:0];
        next_outs.loaded = 1'b1;
      end else if (keep.quad) begin
        next_outs.osh = {outs.osh[3:0], outs.osh[7:4]};
      end else begin
        next_outs.osh = {outs.osh[6:0], outs.osh[7]};
      end
    end
  end

  always_ff @(negedge i_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      outs <= '0;
    end else begin
      outs <= next_outs;
    end
  end

  // hold state changes only at the clock-low state; select high keeps it while the pin stays low
  assign next_held = ~keep.quad & ~i_hold_n & (~i_chip_select_n | held);

  always_ff @(negedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end

  always_comb begin
    o_shared_data_lines    = 4'h0;
    o_shared_data_lines_oe = 4'h0;
    if (rd_active && outs.loaded && !held && !i_chip_select_n) begin
      if (keep.quad) begin
        o_shared_data_lines    = outs.osh[7:4];
        o_shared_data_lines_oe = 4'hF;
      end else begin
        o_shared_data_lines[1]    = outs.osh[7];
        o_shared_data_lines_oe[1] = 1'b1;
      end
    end
  end

  // register image only changes after a command completes, long before the next read frame
  sync_two_flop #(.WIDTH(16)) u_sync_word (
    .i_clk    (i_sck),
    .i_resetn (i_resetn),
    .i_d      ({o_status, o_config}),
    .o_q      (word_link)
  );

  // ---------------- system domain ----------------
  typedef struct packed {
    sys_state_t state;
    logic       tgl_seen;
    logic       strap_done;
    logic       wel;
    logic       busy;
    logic       level0;
    logic       level1;
    logic       lockdown;
    logic       pin_function_select;
    logic       volatile_lock;
    logic       protect_pin_enable;
    logic       secure_id_locked;
    logic       arr_valid;
    array_op_t  arr_op;
  } sys_t;

  sys_t sys, next_sys;
  logic tgl_sys;
  logic wp_n_sys;
  logic quad_sys;
  logic pin_guard;
  logic level_locked;
  logic array_protected;
  logic new_cmd;

  sync_two_flop #(.WIDTH(3)) u_sync_sys (
    .i_clk    (i_clk_sys),
    .i_resetn (i_resetn),
    .i_d      ({keep.tgl, i_write_protect_n, keep.quad}),
    .o_q      ({tgl_sys, wp_n_sys, quad_sys})
  );

  assign new_cmd         = tgl_sys ^ sys.tgl_seen;
  // pin guard exists only outside quad mode, with select 0 and pin-enable 1
  assign pin_guard       = ~wp_n_sys & ~quad_sys & ~sys.pin_function_select & sys.protect_pin_enable;
  assign level_locked    = sys.volatile_lock | (pin_guard & sys.lockdown);
  // any nonzero protection level guards the whole array
  assign array_protected = sys.level0 | sys.level1;

  always_comb begin
    next_sys           = sys;
    next_sys.arr_valid = 1'b0;
    next_sys.tgl_seen  = tgl_sys;
    if (!sys.strap_done) begin
      next_sys.strap_done         = 1'b1;
      next_sys.protect_pin_enable = i_protect_pin_enable_nv;
      next_sys.secure_id_locked   = i_secure_id_locked_nv;
    end
    unique case (sys.state)
      SYS_IDLE: begin
        if (new_cmd) begin
          unique case (keep.cmd.op)
            `OP_WRITE_ENABLE: begin
              next_sys.wel = 1'b1;
            end
            `OP_LOCKDOWN_PROTECT: begin
              next_sys.volatile_lock = sys.volatile_lock | sys.wel;
              next_sys.wel           = 1'b0;
            end
            `OP_STATUS_WRITE: begin
              if (sys.wel) begin
                if (!level_locked && !(pin_guard && sys.lockdown)) begin
                  next_sys.level0   = keep.cmd.data[8 + `ST_LEVEL0];
                  next_sys.level1   = keep.cmd.data[8 + `ST_LEVEL1];
                  next_sys.lockdown = keep.cmd.data[8 + `ST_LOCKDOWN];
                end
                if (!pin_guard) begin
                  next_sys.pin_function_select = keep.cmd.data[`CF_PIN_FUNCTION_SELECT];
                  next_sys.protect_pin_enable  = keep.cmd.data[`CF_PROTECT_PIN_ENABLE];
                end
              end
              next_sys.wel = 1'b0;
            end
            `OP_SECURE_ID_LOCKOUT: begin
              next_sys.secure_id_locked = sys.secure_id_locked | sys.wel;
              next_sys.wel              = 1'b0;
            end
            `OP_SECURE_ID_PROGRAM: begin
              // factory segment and anything past the area are never programmed
              if (sys.wel && !sys.secure_id_locked && keep.cmd.addr >= `SECURE_ID_FACTORY_END &&
                  keep.cmd.addr < `SECURE_ID_AREA_END) begin
                next_sys.arr_valid = 1'b1;
                next_sys.arr_op    = '{kind: ARR_SECURE_ID_PGM, addr: keep.cmd.addr, data: keep.cmd.data[7:0]};
                next_sys.busy      = 1'b1;
                next_sys.state     = SYS_BUSY;
              end
              next_sys.wel = 1'b0;
            end
            `OP_PAGE_PROGRAM, `OP_QUAD_PAGE_PROGRAM: begin
              if (sys.wel && !array_protected) begin
                next_sys.arr_valid = 1'b1;
                next_sys.arr_op    = '{kind: ARR_PROGRAM, addr: keep.cmd.addr, data: keep.cmd.data[7:0]};
                next_sys.busy      = 1'b1;
                next_sys.state     = SYS_BUSY;
              end
              next_sys.wel = 1'b0;
            end
            // erase commands only reach the main array, so the security area cannot be erased
            `OP_SECTOR_ERASE, `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE: begin
              if (sys.wel && !array_protected) begin
                next_sys.arr_valid = 1'b1;
                next_sys.arr_op.kind = ARR_ERASE;
                next_sys.arr_op.data = 8'h00;
                if (keep.cmd.op == `OP_SECTOR_ERASE) begin
                  next_sys.arr_op.addr = keep.cmd.addr & `SECTOR_ADDR_MASK;
                end else if (keep.cmd.op == `OP_BLOCK32_ERASE) begin
                  next_sys.arr_op.addr = keep.cmd.addr & `BLOCK32_ADDR_MASK;
                end else begin
                  next_sys.arr_op.addr = keep.cmd.addr & `BLOCK64_ADDR_MASK;
                end
                next_sys.busy  = 1'b1;
                next_sys.state = SYS_BUSY;
              end
              next_sys.wel = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      SYS_BUSY: begin
        // the protect pin is not looked at here, so it cannot cut a running operation short
        if (i_array_done) begin
          next_sys.busy  = 1'b0;
          next_sys.state = SYS_IDLE;
        end
      end
      default: begin
        next_sys.state = SYS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sys          <= '0;
      sys.state    <= SYS_IDLE;
      sys.level0   <= `STATUS_RESET_LEVEL;
      sys.level1   <= `STATUS_RESET_LEVEL;
      sys.arr_op.kind <= ARR_PROGRAM;
      // volatile lock returns to zero only here
      sys.volatile_lock <= 1'b0;
    end else begin
      sys <= next_sys;
    end
  end

  always_comb begin
    o_status                           = 8'h00;
    o_status[`ST_BUSY]                 = sys.busy;
    o_status[`ST_WEL]                  = sys.wel;
    o_status[`ST_LEVEL0]               = sys.level0;
    o_status[`ST_LEVEL1]               = sys.level1;
    o_status[`ST_LOCKDOWN]             = sys.lockdown;
    o_config                           = 8'h00;
    o_config[`CF_PIN_FUNCTION_SELECT]  = sys.pin_function_select;
    o_config[`CF_VOLATILE_LOCK]        = sys.volatile_lock;
    o_config[`CF_PROTECT_PIN_ENABLE]   = sys.protect_pin_enable;
  end

  assign o_protect_pin_enable_nv = sys.protect_pin_enable;
  assign o_secure_id_locked_nv   = sys.secure_id_locked;
  assign o_array_valid           = sys.arr_valid;
  assign o_array_op              = sys.arr_op;
  assign o_quad_mode             = quad_sys;
endmodule : serial_flash_protect_hold

// ### tb/serial_flash_protect_hold_props.sv
module serial_flash_protect_hold_props (
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_resetn,
  input  wire logic                                i_sck,
  input  wire logic                                i_chip_select_n,
  input  wire logic                                i_hold_n,
  input  wire logic [3:0]                          o_shared_data_lines_oe,
  input  wire logic                                o_array_valid,
  input  wire serial_flash_protect_hold_pkg::array_op_t o_array_op,
  input  wire logic                                i_array_done,
  input  wire logic [7:0]                          o_status,
  input  wire logic [7:0]                          o_config,
  input  wire logic                                o_quad_mode,
  input  wire logic                                o_secure_id_locked_nv
);
  timeunit 1ns;
  timeprecision 1ps;
  import serial_flash_protect_hold_pkg::*;

  sequence s_launch;
    o_array_valid ##1 !o_array_valid;
  endsequence

  a_valid_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) $rose(o_array_valid) |-> s_launch)
    else $error("array launch longer than one cycle");
  a_launch_busy: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) o_array_valid |-> o_status[0])
    else $error("array launch without busy");
  a_done_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_status[0] && i_array_done |=> !o_status[0]) else $error("busy not cleared by done");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_status[6:4] == 3'h0 && (o_config & 8'h75) == 8'h00) else $error("reserved bit set");
  a_lock_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) o_config[3] |=> o_config[3])
    else $error("volatile lock cleared without reset");
  a_levels_frozen: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_config[3] |=> $stable(o_status[3:2])) else $error("levels changed under volatile lock");
  a_protect_array: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_array_valid && o_array_op.kind != ARR_SECURE_ID_PGM |-> o_status[3:2] == 2'b00)
    else $error("array write launched while protected");
  a_secid_window: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    o_array_valid && o_array_op.kind == ARR_SECURE_ID_PGM |-> o_array_op.addr >= 24'h000010
    && o_array_op.addr < 24'h000800 && !o_secure_id_locked_nv) else $error("bad security area program");
  a_oe_deselect: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    i_chip_select_n |-> o_shared_data_lines_oe == 4'h0) else $error("driving while deselected");
  a_hold_quiet: assert property (@(posedge i_sck) disable iff (!i_resetn || i_chip_select_n)
    !i_hold_n && !$past(i_hold_n) && !o_quad_mode |-> o_shared_data_lines_oe == 4'h0)
    else $error("driving while held");
  a_quad_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) o_quad_mode |=> o_quad_mode)
    else $error("quad mode dropped");
endmodule : serial_flash_protect_hold_props

bind serial_flash_protect_hold serial_flash_protect_hold_props u_props (.i_clk_sys, .i_resetn, .i_sck,
  .i_chip_select_n, .i_hold_n, .o_shared_data_lines_oe, .o_array_valid, .o_array_op, .i_array_done,
  .o_status, .o_config, .o_quad_mode, .o_secure_id_locked_nv);

// ### tb/serial_host_model.sv
module serial_host_model (
  output logic            o_sck,
  output logic            o_chip_select_n,
  output logic            o_hold_n,
  output logic      [3:0] o_data,
  input  wire logic [3:0] i_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_low;
  // clock parks low between frames (mode 0)
  initial begin
    o_sck = 1'b0;
    o_chip_select_n = 1'b1;
    o_hold_n = 1'b1;
    o_data = 4'h0;
    hold_low = 1'b0;
  end
  task automatic xfer(input logic [39:0] v, input int n, input bit quad, input int hold_at, output logic [7:0] rd);
    int i;
    int k;
    int st;
    st = quad ? 4 : 1;
    rd = 8'h00;
    o_hold_n = !hold_low;
    // small offset keeps link edges away from the system clock edges
    #7 o_chip_select_n = 1'b0;
    for (i = 0; i < n; i = i + st) begin
      // garbage clocks while held must not be taken as data
      if (i == hold_at) begin
        for (k = 0; k < 3; k++) begin
          o_data = ~o_data;
          #80 o_sck = 1'b1;
          #40 if (k == 2) o_hold_n = 1'b1;
          #40 o_sck = 1'b0;
        end
      end
      #40 if (quad) o_data = v[39-i -: 4]; else o_data[0] = v[39-i];
      #40 o_sck = 1'b1;
      rd = quad ? {rd[3:0], i_lines} : {rd[6:0], i_lines[1]};
      #40 if (i + st == hold_at) o_hold_n = 1'b0;
      #40 o_sck = 1'b0;
    end
    #80 o_chip_select_n = 1'b1;
    o_hold_n = 1'b1;
    // released lines do not keep their last value
    o_data = ~o_data;
  endtask : xfer
endmodule : serial_host_model

// ### tb/serial_flash_protect_hold_tb.sv
module serial_flash_protect_hold_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_flash_protect_hold_pkg::*;
  `include "serial_flash_protect_hold_params.svh"
  logic clk = 0, rstn = 0, rs = 0, wp_n = 1, done = 0, pen = 0, sidl = 0, opv, osl, valid, qm, sck, csn, hold_n;
  logic [3:0] hd, dout, oe, lines;
  logic [7:0] st, cf;
  logic [2:0] dpipe = 3'h0;
  array_op_t op, got;
  bit qsel = 0;
  int error_cnt = 0, checks = 0, n_ops = 0;
  always #20 clk = ~clk;
  assign lines = (oe & dout) | (~oe & hd);
  serial_host_model host (.o_sck(sck), .o_chip_select_n(csn), .o_hold_n(hold_n), .o_data(hd), .i_lines(lines));
  serial_flash_protect_hold DUT (.i_clk_sys(clk), .i_resetn(rstn), .i_sck(sck), .i_chip_select_n(csn),
    .i_hold_n(hold_n), .i_write_protect_n(wp_n), .i_shared_data_lines(lines), .o_shared_data_lines(dout),
    .o_shared_data_lines_oe(oe), .i_protect_pin_enable_nv(pen), .i_secure_id_locked_nv(sidl),
    .o_protect_pin_enable_nv(opv), .o_secure_id_locked_nv(osl), .o_array_valid(valid), .o_array_op(op),
    .i_array_done(done), .o_status(st), .o_config(cf), .o_quad_mode(qm));
  always @(posedge clk) begin
    rs <= rstn;
    if (valid) begin
      got <= op;
      n_ops <= n_ops + 1;
    end
  end
  // array answers four cycles after each launch; nonvolatile bits written back as a store would
  always @(negedge clk) begin
    dpipe <= {dpipe[1:0], valid};
    done <= dpipe[2];
    // skip the edges while reset is low and the one on which it rises, so the stored bits survive it
    if (rs && rstn) begin
      pen <= opv;
      sidl <= osl;
    end
  end
  task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic do_reset;
    rstn = 1'b0;
    cyc(6);
    rstn = 1'b1;
    cyc(3);
  endtask : do_reset
  task automatic cmd(input logic [7:0] o, input logic [31:0] p, input int n);
    logic [7:0] rd;
    host.xfer({o, p}, n, qsel, -1, rd);
    cyc(10);
  endtask : cmd
  task automatic wcmd(input logic [7:0] o, input logic [31:0] p, input int n);
    cmd(`OP_WRITE_ENABLE, 32'h0, 8);
    cmd(o, p, n);
  endtask : wcmd
  task automatic status_write_cmd(input logic [7:0] s, input logic [7:0] c);
    wcmd(`OP_STATUS_WRITE, {s, c, 16'h0}, 24);
  endtask : status_write_cmd
  task automatic t_protected_array;
    int b;
    b = n_ops;
    chk("status", 8'h0C, st);
    chk("config", 8'h00, cf);
    wcmd(`OP_PAGE_PROGRAM, 32'h0001005A, 40);
    chk("ops", b, n_ops);
    status_write_cmd(8'h00, 8'h00);
    chk("status", 8'h00, st);
  endtask : t_protected_array
  task automatic t_array_ops;
    logic [7:0] ops[4] = '{`OP_PAGE_PROGRAM, `OP_SECTOR_ERASE, `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE};
    logic [23:0] msk[4] = '{24'hFFFFFF, `SECTOR_ADDR_MASK, `BLOCK32_ADDR_MASK, `BLOCK64_ADDR_MASK};
    int b;
    for (int i = 0; i < 4; i++) begin
      b = n_ops;
      wcmd(ops[i], 32'h03ABCDA5, i == 0 ? 40 : 32);
      chk("ops", b + 1, n_ops);
      chk("op", {i == 0 ? ARR_PROGRAM : ARR_ERASE, 24'h03ABCD & msk[i]}, got[34:8]);
      chk("status", 8'h00, st);
    end
  endtask : t_array_ops
  task automatic t_secure_id;
    int b;
    b = n_ops;
    wcmd(`OP_SECURE_ID_PROGRAM, 32'h00000511, 40);
    chk("ops", b, n_ops);
    wcmd(`OP_SECURE_ID_PROGRAM, 32'h0000203C, 40);
    chk("op", {ARR_SECURE_ID_PGM, 24'h000020, 8'h3C}, got);
    wcmd(`OP_SECURE_ID_LOCKOUT, 32'h0, 8);
    chk("secid lock", 1'b1, osl);
    b = n_ops;
    wcmd(`OP_SECURE_ID_PROGRAM, 32'h0000303C, 40);
    chk("ops", b, n_ops);
  endtask : t_secure_id
  task automatic t_volatile_lock;
    cmd(`OP_LOCKDOWN_PROTECT, 32'h0, 8);
    chk("config", 8'h00, cf);
    wcmd(`OP_LOCKDOWN_PROTECT, 32'h0, 8);
    chk("config", 8'h08, cf);
    status_write_cmd(8'h0C, 8'h00);
    chk("status", 8'h00, st);
  endtask : t_volatile_lock
  task automatic t_pin_guard;
    int b;
    wp_n = 1'b0;
    b = n_ops;
    wcmd(`OP_PAGE_PROGRAM, 32'h000100C3, 40);
    chk("ops", b + 1, n_ops);
    chk("status", 8'h00, st);
    status_write_cmd(8'h00, 8'h82);
    chk("config", 8'h8A, cf);
    status_write_cmd(8'h00, 8'h80);
    chk("config", 8'h88, cf);
    status_write_cmd(8'h00, 8'h00);
    chk("config", 8'h88, cf);
  endtask : t_pin_guard
  task automatic t_reset_lockdown;
    do_reset;
    chk("config", 8'h80, cf);
    status_write_cmd(8'h80, 8'h80);
    chk("status", 8'h80, st);
    status_write_cmd(8'h8C, 8'h80);
    chk("status", 8'h80, st);
  endtask : t_reset_lockdown
  task automatic t_hold_read;
    logic [7:0] rd;
    host.xfer({`OP_STATUS_READ, 32'h0}, 24, 1'b0, 12, rd);
    cyc(4);
    chk("read", 8'h80, rd);
  endtask : t_hold_read
  task automatic t_quad;
    logic [7:0] rd;
    cmd(`OP_QUAD_IO_ENTER, 32'h0, 8);
    chk("quad", 1'b1, qm);
    qsel = 1'b1;
    host.hold_low = 1'b1;
    host.xfer({`OP_CONFIG_READ, 32'h0}, 16, 1'b1, -1, rd);
    cyc(4);
    chk("read", 8'h80, rd);
    status_write_cmd(8'h00, 8'h00);
    chk("status", 8'h00, st);
    chk("config", 8'h00, cf);
    host.hold_low = 1'b0;
  endtask : t_quad
  initial begin
    do_reset;
    t_protected_array;
    t_array_ops;
    t_secure_id;
    t_volatile_lock;
    t_pin_guard;
    t_reset_lockdown;
    t_hold_read;
    t_quad;
    complete_run;
  end
endmodule : serial_flash_protect_hold_tb
